// [verilog/rscb_cfg.svh]
// register indices, field positions, reset values and bus codes of the readout status bank
// Behaviour
// - extended_config bit 1 set suppresses calibration events after the latency period
// - extended_config bit 0 set disables the delay-locked loop logic
// - status bit 7 out-of-sync flag sticks until realign command or reset
// - status bit 6 shows the current optical link ready level
// - bits 7..4 flag data-valid outside a readout cycle, channels D..A
// - readout sequence flags stay set until realign command or reset
// - bits 3..0 flag out-of-sequence FIFO almost-full, channels D..A
// - FIFO sequence flags stay set until realign command or reset
// - both status registers are read-only; a realign command clears their flags but not the link ready bit 6
// - calibration event starts after a software-set latency in clock cycles
`ifndef RSCB_CFG_SVH
`define RSCB_CFG_SVH

`define RSCB_ADDR_W 8
`define RSCB_IDX_SYNC_LINK_STATUS 6'h10
`define RSCB_IDX_READOUT_SEQ_STATUS 6'h11
`define RSCB_IDX_EXTENDED_CONFIG 6'h20
`define RSCB_IDX_CAL_LATENCY 6'h21
`define RSCB_IDX_IRQ_STATUS 6'h22
`define RSCB_IDX_IRQ_MASK 6'h23

`define RSCB_ECFG_DLL_OFF_BIT 0
`define RSCB_ECFG_CAL_SUPPRESS_BIT 1
`define RSCB_ECFG_WRITE_MASK 8'h03
`define RSCB_SYNC_OOS_BIT 7
`define RSCB_SYNC_LINK_READY_BIT 6
`define RSCB_RSEQ_LSB 4
`define RSCB_FSEQ_LSB 0
`define RSCB_CHANNELS 4

`define RSCB_IRQ_OOS_BIT 0
`define RSCB_IRQ_RSEQ_BIT 1
`define RSCB_IRQ_FSEQ_BIT 2
`define RSCB_IRQ_CAL_BIT 3

`define RSCB_ECFG_RESET 8'h00
`define RSCB_LATENCY_RESET 8'h01
`define RSCB_IRQ_MASK_RESET 4'h0

`define RSCB_RESP_OKAY 2'h0
`define RSCB_RESP_SLVERR 2'h2

`endif

// [verilog/rscb_pkg.sv]
// types shared by the readout status bank
package rscb_pkg;

	typedef enum logic [0:0] {
		RSCB_CAL_IDLE,
		RSCB_CAL_WAIT
	} rscb_cal_state_type;

	typedef enum logic [2:0] {
		RSCB_SEL_NONE,
		RSCB_SEL_SYNC,
		RSCB_SEL_RSEQ,
		RSCB_SEL_ECFG,
		RSCB_SEL_LAT,
		RSCB_SEL_IRQS,
		RSCB_SEL_IRQM
	} rscb_reg_sel_type;

endpackage

// [verilog/rscb_bank.sv]
// readout status and extended configuration bank with an AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "rscb_cfg.svh"

module rscb_bank
	import rscb_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [`RSCB_ADDR_W-1:0] i_axi_awaddr,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	output logic [1:0] o_axi_bresp,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	input wire logic [`RSCB_ADDR_W-1:0] i_axi_araddr,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	input wire logic i_realign_command,
	input wire logic i_out_of_sync_event,
	input wire logic i_optical_link_ready,
	input wire logic [`RSCB_CHANNELS-1:0] i_sample_valid_strobe,
	input wire logic [`RSCB_CHANNELS-1:0] i_readout_window,
	input wire logic [`RSCB_CHANNELS-1:0] i_fifo_seq_violation,
	input wire logic i_calibration_trigger,
	output logic o_calibration_event,
	output logic o_dll_disable,
	output logic o_irq
);

	// word index decode, shared by read and write paths
	function automatic rscb_reg_sel_type rscb_decode(input logic [`RSCB_ADDR_W-1:0] addr);
		rscb_reg_sel_type sel;
		sel = RSCB_SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[`RSCB_ADDR_W-1:2])
				`RSCB_IDX_SYNC_LINK_STATUS: sel = RSCB_SEL_SYNC;
				`RSCB_IDX_READOUT_SEQ_STATUS: sel = RSCB_SEL_RSEQ;
				`RSCB_IDX_EXTENDED_CONFIG: sel = RSCB_SEL_ECFG;
				`RSCB_IDX_CAL_LATENCY: sel = RSCB_SEL_LAT;
				`RSCB_IDX_IRQ_STATUS: sel = RSCB_SEL_IRQS;
				`RSCB_IDX_IRQ_MASK: sel = RSCB_SEL_IRQM;
				default: sel = RSCB_SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	logic aw_held_q;
	logic [`RSCB_ADDR_W-1:0] aw_addr_q;
	logic w_held_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic lane0_write;
	rscb_reg_sel_type wr_sel;
	rscb_reg_sel_type rd_sel;
	logic [7:0] rd_byte;

	logic [7:0] ext_config_q;
	logic [7:0] latency_q;
	logic chip_out_of_sync_flag_q;
	logic [`RSCB_CHANNELS-1:0] readout_seq_error_q;
	logic [`RSCB_CHANNELS-1:0] fifo_seq_error_q;
	logic [`RSCB_CHANNELS-1:0] readout_seq_set;
	logic [3:0] irq_status_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_event;
	logic [3:0] irq_clear;

	rscb_cal_state_type cal_state_q;
	logic [7:0] cal_count_q;
	logic cal_expire;
	logic cal_event_q;

	// bus handshakes
	assign o_axi_awready = !aw_held_q && !bvalid_q;
	assign o_axi_wready = !w_held_q && !bvalid_q;
	assign o_axi_bvalid = bvalid_q;
	assign o_axi_bresp = bresp_q;
	assign o_axi_arready = !rvalid_q;
	assign o_axi_rvalid = rvalid_q;
	assign o_axi_rdata = rdata_q;
	assign o_axi_rresp = rresp_q;

	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_sel = rscb_decode(aw_addr_q);
	assign rd_sel = rscb_decode(i_axi_araddr);
	assign lane0_write = do_write && w_strb_q[0];

	// write address capture
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (i_axi_awvalid && o_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= i_axi_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	// write data capture
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (i_axi_wvalid && o_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= i_axi_wdata;
			w_strb_q <= i_axi_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	// write response; writes to read-only words are ignored with okay
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RSCB_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == RSCB_SEL_NONE) ? `RSCB_RESP_SLVERR : `RSCB_RESP_OKAY;
		end else if (i_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read word assembly
	always_comb begin
		rd_byte = 8'h00;
		case (rd_sel)
			RSCB_SEL_SYNC: begin
				rd_byte[`RSCB_SYNC_OOS_BIT] = chip_out_of_sync_flag_q;
				rd_byte[`RSCB_SYNC_LINK_READY_BIT] = i_optical_link_ready;
			end
			RSCB_SEL_RSEQ: begin
				rd_byte = {readout_seq_error_q, fifo_seq_error_q};
			end
			RSCB_SEL_ECFG: begin
				rd_byte = ext_config_q & `RSCB_ECFG_WRITE_MASK;
			end
			RSCB_SEL_LAT: begin
				rd_byte = latency_q;
			end
			RSCB_SEL_IRQS: begin
				rd_byte = {4'h0, irq_status_q};
			end
			RSCB_SEL_IRQM: begin
				rd_byte = {4'h0, irq_mask_q};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// read channel
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RSCB_RESP_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, rd_byte};
			rresp_q <= (rd_sel == RSCB_SEL_NONE) ? `RSCB_RESP_SLVERR : `RSCB_RESP_OKAY;
		end else if (i_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// extended configuration, only the two defined bits store
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ext_config_q <= `RSCB_ECFG_RESET;
		end else if (lane0_write && wr_sel == RSCB_SEL_ECFG) begin
			ext_config_q <= w_data_q[7:0] & `RSCB_ECFG_WRITE_MASK;
		end
	end

	assign o_dll_disable = ext_config_q[`RSCB_ECFG_DLL_OFF_BIT];

	// calibration latency
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			latency_q <= `RSCB_LATENCY_RESET;
		end else if (lane0_write && wr_sel == RSCB_SEL_LAT) begin
			latency_q <= w_data_q[7:0];
		end
	end

	// out-of-sync flag, realign wins over a set
	always_ff @(posedge i_clk) begin
		if (i_reset || i_realign_command) begin
			chip_out_of_sync_flag_q <= 1'b0;
		end else if (i_out_of_sync_event) begin
			chip_out_of_sync_flag_q <= 1'b1;
		end
	end

	// per-channel sequence error flags
	generate
		for (genvar ch = 0; ch < `RSCB_CHANNELS; ch++) begin : g_chan
			assign readout_seq_set[ch] = i_sample_valid_strobe[ch] && !i_readout_window[ch];

			always_ff @(posedge i_clk) begin
				if (i_reset || i_realign_command) begin
					readout_seq_error_q[ch] <= 1'b0;
				end else if (readout_seq_set[ch]) begin
					readout_seq_error_q[ch] <= 1'b1;
				end
			end

			always_ff @(posedge i_clk) begin
				if (i_reset || i_realign_command) begin
					fifo_seq_error_q[ch] <= 1'b0;
				end else if (i_fifo_seq_violation[ch]) begin
					fifo_seq_error_q[ch] <= 1'b1;
				end
			end
		end
	endgenerate

	// calibration latency timer
	assign cal_expire = (cal_state_q == RSCB_CAL_WAIT) && !i_calibration_trigger
		&& (cal_count_q <= 8'h01);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cal_state_q <= RSCB_CAL_IDLE;
			cal_count_q <= 8'h00;
		end else begin
			case (cal_state_q)
				RSCB_CAL_IDLE: begin
					if (i_calibration_trigger) begin
						cal_state_q <= RSCB_CAL_WAIT;
						cal_count_q <= latency_q;
					end
				end
				RSCB_CAL_WAIT: begin
					if (i_calibration_trigger) begin
						cal_count_q <= latency_q;
					end else if (cal_count_q <= 8'h01) begin
						cal_state_q <= RSCB_CAL_IDLE;
					end else begin
						cal_count_q <= 8'(cal_count_q - 8'h01);
					end
				end
				default: begin
					cal_state_q <= RSCB_CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cal_event_q <= 1'b0;
		end else begin
			cal_event_q <= cal_expire && !ext_config_q[`RSCB_ECFG_CAL_SUPPRESS_BIT];
		end
	end

	assign o_calibration_event = cal_event_q;

	// interrupt status, set wins over write-one-to-clear
	assign irq_event[`RSCB_IRQ_OOS_BIT] = i_out_of_sync_event && !i_realign_command;
	assign irq_event[`RSCB_IRQ_RSEQ_BIT] = (|readout_seq_set) && !i_realign_command;
	assign irq_event[`RSCB_IRQ_FSEQ_BIT] = (|i_fifo_seq_violation) && !i_realign_command;
	assign irq_event[`RSCB_IRQ_CAL_BIT] = cal_event_q;
	assign irq_clear = (lane0_write && wr_sel == RSCB_SEL_IRQS) ? w_data_q[3:0] : 4'h0;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_status_q <= 4'h0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_mask_q <= `RSCB_IRQ_MASK_RESET;
		end else if (lane0_write && wr_sel == RSCB_SEL_IRQM) begin
			irq_mask_q <= w_data_q[3:0];
		end
	end

	assign o_irq = |(irq_status_q & irq_mask_q);

	// checks
	cal_fires_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(cal_expire && !ext_config_q[`RSCB_ECFG_CAL_SUPPRESS_BIT]) |=> o_calibration_event)
		else $error("calibration event missing after latency");

	cal_suppress_a: assert property (@(posedge i_clk) disable iff (i_reset)
		o_calibration_event |-> !$past(ext_config_q[`RSCB_ECFG_CAL_SUPPRESS_BIT]))
		else $error("calibration event while suppressed");

	dll_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(lane0_write && wr_sel == RSCB_SEL_ECFG) |=> (o_dll_disable == $past(w_data_q[0])))
		else $error("dll disable does not follow write");

	oos_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(chip_out_of_sync_flag_q && !i_realign_command) |=> chip_out_of_sync_flag_q)
		else $error("out-of-sync flag dropped");

	link_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_axi_arvalid && o_axi_arready && rd_sel == RSCB_SEL_SYNC)
		|=> (o_axi_rdata[`RSCB_SYNC_LINK_READY_BIT] == $past(i_optical_link_ready)))
		else $error("link ready bit not mirrored");

	rseq_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(readout_seq_set[0] && !i_realign_command) |=> readout_seq_error_q[0])
		else $error("readout sequence flag not set");

	rseq_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!i_realign_command |=> ((readout_seq_error_q & $past(readout_seq_error_q))
		== $past(readout_seq_error_q)))
		else $error("readout sequence flag dropped");

	fseq_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_fifo_seq_violation[3] && !i_realign_command) |=> fifo_seq_error_q[3])
		else $error("fifo sequence flag not set");

	fseq_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!i_realign_command |=> ((fifo_seq_error_q & $past(fifo_seq_error_q))
		== $past(fifo_seq_error_q)))
		else $error("fifo sequence flag dropped");

	realign_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
		i_realign_command |=> (!chip_out_of_sync_flag_q && readout_seq_error_q == 4'h0
		&& fifo_seq_error_q == 4'h0))
		else $error("status not cleared by realign");

	cal_latency_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_calibration_trigger && latency_q == 8'h03 && !ext_config_q[1])
		##1 (!i_calibration_trigger && !ext_config_q[1])[*3] |=> o_calibration_event)
		else $error("calibration latency wrong");

	ecfg_reserved_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_axi_arvalid && o_axi_arready && rd_sel == RSCB_SEL_ECFG)
		|=> (o_axi_rdata[7:2] == 6'h00))
		else $error("reserved config bits read non-zero");

	realign_wins_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_realign_command && (i_out_of_sync_event || readout_seq_set != 4'h0
		|| i_fifo_seq_violation != 4'h0))
		|=> (!chip_out_of_sync_flag_q && readout_seq_error_q == 4'h0
		&& fifo_seq_error_q == 4'h0))
		else $error("set beat realign");

endmodule

// [tb/rscb_fe_model.sv]
// four front-end readout channels feeding the readout status bank
`timescale 1ns/100ps
module rscb_fe_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_bad_rd,
	input wire logic [3:0] i_bad_ff,
	output logic [3:0] o_sample_valid_strobe,
	output logic [3:0] o_readout_window,
	output logic [3:0] o_fifo_seq_violation
);
	// one readout cycle per go; a bad channel strobes with its window shut
	always_ff @(posedge i_clk) begin
		o_readout_window <= i_go ? ~i_bad_rd : 4'h0;
		o_sample_valid_strobe <= i_go ? 4'hF : 4'h0;
		o_fifo_seq_violation <= i_go ? i_bad_ff : 4'h0;
	end
endmodule

// [tb/rscb_bank_tb_top.sv]
// self-checking bench for the readout status bank
`timescale 1ns/100ps
module rscb_bank_tb_top;
	logic i_clk = '0, i_reset = '1, i_axi_awvalid = '0, i_axi_wvalid = '0, i_axi_bready = '0;
	logic i_axi_arvalid = '0, i_axi_rready = '0, i_realign_command = '0, i_out_of_sync_event = '0;
	logic i_optical_link_ready = '1, i_calibration_trigger = '0, go = '0;
	logic [7:0] i_axi_awaddr = '0, i_axi_araddr = '0, v;
	logic [31:0] i_axi_wdata = '0, o_axi_rdata;
	logic [3:0] i_axi_wstrb = 4'h1, bad_rd = '0, bad_ff = '0;
	logic [3:0] i_sample_valid_strobe, i_readout_window, i_fifo_seq_violation;
	logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
	logic o_calibration_event, o_dll_disable, o_irq;
	logic [1:0] o_axi_bresp, o_axi_rresp;
	logic [33:0] wq[$], rq[$];
	int error_cnt = 0, checked = 0, cyc = 0, n;

	rscb_bank rscb_bank_inst (.i_clk, .i_reset, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
		.i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready,
		.o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .i_axi_araddr, .o_axi_rvalid,
		.i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_realign_command, .i_out_of_sync_event,
		.i_optical_link_ready, .i_sample_valid_strobe, .i_readout_window, .i_fifo_seq_violation,
		.i_calibration_trigger, .o_calibration_event, .o_dll_disable, .o_irq);
	rscb_fe_model rscb_fe_model_inst (.i_clk, .i_go(go), .i_bad_rd(bad_rd), .i_bad_ff(bad_ff),
		.o_sample_valid_strobe(i_sample_valid_strobe), .o_readout_window(i_readout_window),
		.o_fifo_seq_violation(i_fifo_seq_violation));

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	task automatic results();
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH bus t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH pin t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// responses checked as they appear
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_axi_bvalid === 1'h1 && i_axi_bready) cmp_bus({o_axi_bresp, 32'h0}, wq.pop_front());
		if (o_axi_rvalid === 1'h1 && i_axi_rready) cmp_bus({o_axi_rresp, o_axi_rdata}, rq.pop_front());
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		wq.push_back({r, 32'h0});
		i_axi_awvalid <= 1'h1;
		i_axi_awaddr <= a;
		i_axi_wvalid <= 1'h1;
		i_axi_wdata <= {24'($urandom), d};
		i_axi_bready <= 1'h1;
		do begin
			@(posedge i_clk);
			if (o_axi_awready) i_axi_awvalid <= 1'h0;
			if (o_axi_wready) i_axi_wvalid <= 1'h0;
		end while (o_axi_bvalid !== 1'h1);
		i_axi_bready <= 1'h0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		rq.push_back({r, 24'h0, d});
		i_axi_arvalid <= 1'h1;
		i_axi_araddr <= a;
		i_axi_rready <= 1'h1;
		do begin
			@(posedge i_clk);
			if (o_axi_arready) i_axi_arvalid <= 1'h0;
		end while (o_axi_rvalid !== 1'h1);
		i_axi_rready <= 1'h0;
		@(posedge i_clk);
	endtask

	// one-cycle pulse on realign (bit 1) and out-of-sync (bit 0)
	task automatic pul(input logic [1:0] k);
		{i_realign_command, i_out_of_sync_event} <= k;
		@(posedge i_clk);
		{i_realign_command, i_out_of_sync_event} <= 2'h0;
		@(posedge i_clk);
	endtask

	task automatic cal_run(input logic [7:0] lat, input logic [1:0] cfg);
		wr(8'h80, {6'h00, cfg}, 2'h0);
		wr(8'h84, lat, 2'h0);
		i_calibration_trigger <= 1'h1;
		@(posedge i_clk);
		i_calibration_trigger <= 1'h0;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_calibration_event !== 1'h1 && n < 40);
	endtask

	initial begin
		void'($urandom(32'h4528));
		repeat (16) @(posedge i_clk);
		i_reset <= 1'h0;
		@(posedge i_clk);
		rd(8'h80, 8'h00, 2'h0);
		rd(8'h84, 8'h01, 2'h0);
		rd(8'h8C, 8'h00, 2'h0);
		rd(8'h44, 8'h00, 2'h0);
		rd(8'h40, 8'h40, 2'h0);
		i_optical_link_ready <= 1'h0;
		rd(8'h40, 8'h00, 2'h0);
		i_optical_link_ready <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			v = {6'($urandom), 2'(i)};
			wr(8'h80, v, 2'h0);
			rd(8'h80, v & 8'h03, 2'h0);
			cmp_pin({31'h0, o_dll_disable}, {31'h0, v[0]});
		end
		i_axi_wstrb <= 4'h0;
		wr(8'h80, 8'h00, 2'h0);
		i_axi_wstrb <= 4'h1;
		rd(8'h80, 8'h03, 2'h0);
		wr(8'h44, 8'hFF, 2'h0);
		rd(8'h44, 8'h00, 2'h0);
		wr(8'hFC, 8'h5A, 2'h2);
		rd(8'hFC, 8'h00, 2'h2);
		pul(2'h1);
		rd(8'h40, 8'hC0, 2'h0);
		repeat (20) @(posedge i_clk);
		rd(8'h40, 8'hC0, 2'h0);
		pul(2'h2);
		rd(8'h40, 8'h40, 2'h0);
		pul(2'h3);
		rd(8'h40, 8'h40, 2'h0);
		repeat (4) begin
			bad_rd <= 4'($urandom);
			bad_ff <= 4'($urandom);
			go <= 1'h1;
			@(posedge i_clk);
			go <= 1'h0;
			repeat (3) @(posedge i_clk);
			rd(8'h44, {bad_rd, bad_ff}, 2'h0);
			repeat (10) @(posedge i_clk);
			rd(8'h44, {bad_rd, bad_ff}, 2'h0);
			pul(2'h2);
			rd(8'h44, 8'h00, 2'h0);
		end
		// error strobes in the same cycle as realign leave the flags clear
		bad_rd <= 4'hF;
		bad_ff <= 4'hF;
		go <= 1'h1;
		@(posedge i_clk);
		go <= 1'h0;
		pul(2'h2);
		rd(8'h44, 8'h00, 2'h0);
		wr(8'h88, 8'h0F, 2'h0);
		wr(8'h8C, 8'h01, 2'h0);
		cmp_pin({31'h0, o_irq}, 32'h0);
		pul(2'h1);
		cmp_pin({31'h0, o_irq}, 32'h1);
		rd(8'h88, 8'h01, 2'h0);
		wr(8'h88, 8'h01, 2'h0);
		cmp_pin({31'h0, o_irq}, 32'h0);
		wr(8'h8C, 8'h00, 2'h0);
		pul(2'h1);
		cmp_pin({31'h0, o_irq}, 32'h0);
		rd(8'h88, 8'h01, 2'h0);
		v = 8'(2 + $urandom % 20);
		cal_run(v, 2'h0);
		cmp_pin(32'(n), 32'(v) + 32'h1);
		cal_run(8'h00, 2'h0);
		cmp_pin(32'(n), 32'h2);
		cal_run(8'h03, 2'h0);
		cmp_pin(32'(n), 32'h4);
		cal_run(v, 2'h2);
		cmp_pin(32'(n), 32'd40);
		cmp_pin({31'h0, o_dll_disable}, 32'h0);
		rd(8'h88, 8'h09, 2'h0);
		results();
	end
endmodule
